/* File: rtl/peripheral_interrupt_flags.sv */
`timescale 1ns/100ps
`include "pif_cfg.svh"

// How it works
// - Master transfer or sequence done sets serial flag
// - Bus start/stop while idle in a multi-master system sets serial flag
// - Serial flag at bit 3, zero after reset
// - Unit one capture/compare sets bit 2
// - Unit two capture sets sticky flag
// - Unit two compare sets sticky; PWM none
// - Timer-two period match sets bit 1
// - Timer-one overflow sets bit 0, cleared by 0
// - Second enable bit 0, read/write, reset 0
// - Second registers bits 7..1 read zero
// - Flags set regardless of any enable
// - Second flag register bit 0 at 0Dh
// - Enables gate interrupt, not flag recording

module peripheral_interrupt_flags
  import pif_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire reg_req_s reg_req,
  output logic [7:0] rd_data,
  // Global enable from the interrupt control logic
  input wire logic global_interrupt_enable,
  // Peripheral events, same clock
  input wire serial_ev_s serial_ev,
  input wire capcomp_ev_s capcomp_one,
  input wire capcomp_ev_s capcomp_two,
  input wire logic timer_two_tick,
  input wire logic [7:0] timer_two_count,
  input wire logic [7:0] timer_two_period,
  input wire logic timer_one_overflow,
  // Interrupt request to the core
  output logic periph_irq
);

  // ****************************************
  // Event decode
  // ****************************************

  // Set strobes per flag bit of the first register
  logic [3:0] set1;
  // Set strobe of the second flag
  logic set2;
  // Serial module event terms
  logic serial_master_ev;
  logic serial_bus_ev;
  // Capture/compare event terms
  logic cc1_ev;
  logic period_hit;

  // Event classification, independent of any enable
  always_comb
  begin
    // Only sequences the module started as master count here
    serial_master_ev = serial_ev.i2c_master
      & (serial_ev.xfer_done | serial_ev.seq_done);
    // Bus conditions only count while idle in a multi-master system
    serial_bus_ev = serial_ev.multi_master & serial_ev.module_idle
      & (serial_ev.bus_start | serial_ev.bus_stop);
    // PWM and off modes never raise the unit flag
    cc1_ev = ((capcomp_one.mode == CC_CAPTURE) & capcomp_one.capture)
      | ((capcomp_one.mode == CC_COMPARE) & capcomp_one.match);
    // Gated by the tick so a held equal count sets the flag once
    period_hit = timer_two_tick & (timer_two_count == timer_two_period);
    set1 = '0;
    set1[`PIF_BIT_SERIAL] = serial_master_ev | serial_bus_ev;
    set1[`PIF_BIT_CC1] = cc1_ev;
    set1[`PIF_BIT_PMATCH] = period_hit;
    set1[`PIF_BIT_T1OVF] = timer_one_overflow;
    // Capture in capture mode, match in compare mode
    case (capcomp_two.mode)
      CC_CAPTURE: set2 = capcomp_two.capture;
      CC_COMPARE: set2 = capcomp_two.match;
      CC_PWM: set2 = 1'b0;
      default: set2 = 1'b0;
    endcase
  end

  // ****************************************
  // Register decode
  // ****************************************

  // Write selects
  logic wr_f1;
  logic wr_f2;
  logic wr_e1;
  logic wr_e2;

  // Address decode for writes
  always_comb
  begin
    wr_f1 = reg_req.wr & (reg_req.addr == `PIF_OFS_FLAG1);
    wr_f2 = reg_req.wr & (reg_req.addr == `PIF_OFS_FLAG2);
    wr_e1 = reg_req.wr & (reg_req.addr == `PIF_OFS_EN1);
    wr_e2 = reg_req.wr & (reg_req.addr == `PIF_OFS_EN2);
  end

  // ****************************************
  // State update
  // ****************************************

  // Registered state and its next value
  pif_state_s state_ff;
  pif_state_s nxt_state;

  // Flags, enables, read data and request
  always_comb
  begin
    nxt_state = state_ff;
    // Flags: a write stores, a hardware set always wins
    if (wr_f1)
    begin
      nxt_state.flags1 = reg_req.wdata[3:0];
    end
    nxt_state.flags1 = nxt_state.flags1 | set1;
    if (wr_f2)
    begin
      nxt_state.flag2 = reg_req.wdata[`PIF_BIT_CC2];
    end
    nxt_state.flag2 = nxt_state.flag2 | set2;
    // Enables are plain read/write bits
    if (wr_e1)
    begin
      nxt_state.en1 = reg_req.wdata[3:0];
    end
    if (wr_e2)
    begin
      nxt_state.en2 = reg_req.wdata[0];
    end
    // Read data stands only in the cycle after the strobe
    nxt_state.rdata = `PIF_RST_DATA;
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        // Upper bits of the first register are outside this block
        `PIF_OFS_FLAG1: nxt_state.rdata = {4'h0, state_ff.flags1};
        `PIF_OFS_FLAG2: nxt_state.rdata = {7'h00, state_ff.flag2};
        `PIF_OFS_EN1: nxt_state.rdata = {4'h0, state_ff.en1};
        `PIF_OFS_EN2: nxt_state.rdata = {7'h00, state_ff.en2};
        // Unmapped addresses read zero
        default: nxt_state.rdata = `PIF_RST_DATA;
      endcase
    end
    // Request built from next values so it tracks the flags
    nxt_state.irq = global_interrupt_enable
      & (|(nxt_state.flags1 & nxt_state.en1)
      | (nxt_state.flag2 & nxt_state.en2));
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff.flags1 <= `PIF_RST_FLAGS1;
      state_ff.flag2 <= `PIF_RST_BIT;
      state_ff.en1 <= `PIF_RST_EN1;
      state_ff.en2 <= `PIF_RST_BIT;
      state_ff.rdata <= `PIF_RST_DATA;
      state_ff.irq <= `PIF_RST_BIT;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register
  assign rd_data = state_ff.rdata;
  assign periph_irq = state_ff.irq;

  // ****************************************
  // Checks
  // ****************************************

  // Checks sleep while reset is low and run again from the first edge after it rises
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Sequences
  // ****************************************

  // A software clear of the first flag register
  sequence clr1_s;
    wr_f1 && reg_req.wdata[3:0] == 4'h0;
  endsequence

  // A software clear of the second flag register
  sequence clr2_s;
    wr_f2 && !reg_req.wdata[0];
  endsequence

  // A finished master sequence sets the serial flag
  serial_master_set_a: assert property (
    serial_ev.i2c_master && serial_ev.seq_done
    |=> state_ff.flags1[`PIF_BIT_SERIAL])
    else $error("serial flag missed a master sequence");

  serial_bus_set_a: assert property (
    serial_ev.multi_master && serial_ev.module_idle && serial_ev.bus_stop
    |=> state_ff.flags1[`PIF_BIT_SERIAL])
    else $error("serial flag missed an idle bus stop");

  serial_quiet_a: assert property (
    clr1_s and !serial_master_ev and !serial_bus_ev
    |=> !state_ff.flags1[`PIF_BIT_SERIAL])
    else $error("serial flag set with nothing pending");

  cc_pwm_quiet_a: assert property (
    capcomp_one.mode == CC_PWM and clr1_s
    |=> !state_ff.flags1[`PIF_BIT_CC1])
    else $error("unit one flag set in pwm mode");

  // Unit two flag holds through every cycle without a write to it
  cc2_sticky_a: assert property (
    state_ff.flag2 && !wr_f2 |=> state_ff.flag2)
    else $error("unit two flag dropped without a clear");

  cc2_compare_set_a: assert property (
    capcomp_two.mode == CC_COMPARE && capcomp_two.match
    |=> state_ff.flag2 ##1 (state_ff.flag2 || $past(wr_f2)))
    else $error("unit two compare match lost");

  period_match_a: assert property (
    timer_two_tick && timer_two_count == timer_two_period
    |=> state_ff.flags1[`PIF_BIT_PMATCH])
    else $error("period match flag not set");

  set_beats_clear_a: assert property (
    clr1_s and timer_one_overflow |=> state_ff.flags1[`PIF_BIT_T1OVF])
    else $error("overflow lost to a clear");

  en2_upper_zero_a: assert property (
    reg_req.rd && reg_req.addr == `PIF_OFS_EN2
    |=> rd_data[7:1] == 7'h00 && rd_data[0] == state_ff.en2)
    else $error("second enable read back wrong");

  flag2_read_a: assert property (
    reg_req.rd && reg_req.addr == `PIF_OFS_FLAG2
    |=> rd_data == {7'h00, $past(state_ff.flag2)})
    else $error("second flag read back wrong");

  set_no_enable_a: assert property (
    state_ff.en2 == 1'b0 && capcomp_two.mode == CC_CAPTURE
    && capcomp_two.capture |=> state_ff.flag2)
    else $error("flag not set while disabled");

  irq_gate_a: assert property (
    periph_irq |-> $past(global_interrupt_enable)
    && ((state_ff.flags1 & state_ff.en1) != 4'h0
    || (state_ff.flag2 && state_ff.en2)))
    else $error("request without an enabled flag");

  // A write to flag two or enable two may legally drop the request
  irq_raise_a: assert property (
    global_interrupt_enable && state_ff.en2 && state_ff.flag2 && !wr_f2 && !wr_e2
    |=> periph_irq)
    else $error("request not raised");

  // Software clear of unit two with no event in the same cycle
  flag2_clear_a: assert property (
    clr2_s and !set2 |=> !state_ff.flag2)
    else $error("unit two flag survived a clear");

  // Unit two stays quiet in pwm mode
  cc2_pwm_quiet_a: assert property (
    capcomp_two.mode == CC_PWM and clr2_s |=> !state_ff.flag2)
    else $error("unit two flag set in pwm mode");

  // A finished master transfer sets the serial flag
  serial_xfer_set_a: assert property (
    serial_ev.i2c_master && serial_ev.xfer_done
    |=> state_ff.flags1[`PIF_BIT_SERIAL])
    else $error("serial flag missed a master transfer");

  // A capture in capture mode sets the unit one flag
  cc1_capture_set_a: assert property (
    capcomp_one.mode == CC_CAPTURE && capcomp_one.capture
    |=> state_ff.flags1[`PIF_BIT_CC1])
    else $error("unit one capture lost");

  // Overflow flag holds until software writes the register
  ovf_sticky_a: assert property (
    state_ff.flags1[`PIF_BIT_T1OVF] && !wr_f1 |=> state_ff.flags1[`PIF_BIT_T1OVF])
    else $error("overflow flag dropped without a clear");

  // Without a tick an equal count leaves the match flag clear
  period_quiet_a: assert property (
    clr1_s and !timer_two_tick |=> !state_ff.flags1[`PIF_BIT_PMATCH])
    else $error("period match flag set without a tick");

  // Enable two changes only on a write to its address
  en2_hold_a: assert property (
    !wr_e2 |=> $stable(state_ff.en2))
    else $error("second enable changed without a write");

endmodule // peripheral_interrupt_flags

/* File: rtl/pif_cfg.svh */
`ifndef PIF_CFG_SVH
`define PIF_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PIF_OFS_FLAG1 8'h0c
`define PIF_OFS_FLAG2 8'h0d
`define PIF_OFS_EN1 8'h8c
`define PIF_OFS_EN2 8'h8d

// ****************************************
// Field positions
// ****************************************
`define PIF_BIT_SERIAL 3
`define PIF_BIT_CC1 2
`define PIF_BIT_PMATCH 1
`define PIF_BIT_T1OVF 0
`define PIF_BIT_CC2 0

// ****************************************
// Widths and reset values
// ****************************************
`define PIF_ADDR_W 8
`define PIF_DATA_W 8
`define PIF_F1_W 4
`define PIF_RST_FLAGS1 4'h0
`define PIF_RST_EN1 4'h0
`define PIF_RST_BIT 1'b0
`define PIF_RST_DATA 8'h00

`endif

/* File: rtl/pif_pkg.sv */
package pif_pkg;

  // ****************************************
  // Modes of a capture/compare unit
  // ****************************************
  typedef enum logic [1:0] {
    CC_OFF,
    CC_CAPTURE,
    CC_COMPARE,
    CC_PWM
  } capcomp_mode_e;

  // Register port request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Serial module levels and one-cycle event strobes
  typedef struct packed {
    logic i2c_master;     // Level: module runs as bus master
    logic multi_master;   // Level: multi-master system
    logic module_idle;    // Level: serial module idle
    logic xfer_done;      // Transfer finished
    logic seq_done;       // Start/stop/restart/ack sequence done
    logic bus_start;      // Start seen on the bus
    logic bus_stop;       // Stop seen on the bus
  } serial_ev_s;

  // One capture/compare unit
  typedef struct packed {
    capcomp_mode_e mode;
    logic capture;        // Timer-one value captured
    logic match;          // Timer-one compare match
  } capcomp_ev_s;

  // All block state
  typedef struct packed {
    logic [3:0] flags1;
    logic flag2;
    logic [3:0] en1;
    logic en2;
    logic [7:0] rdata;
    logic irq;
  } pif_state_s;

endpackage

/* File: tb/pif_src.sv */
`timescale 1ns/100ps

// ****************************************
// Peripheral event sources
// ****************************************
module pif_src
  import pif_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Events toward the block
  output serial_ev_s serial_ev,
  output capcomp_ev_s cc_one,
  output capcomp_ev_s cc_two,
  output logic t2_tick,
  output logic [7:0] t2_count,
  output logic [7:0] t2_period,
  output logic t1_ovf
);
  // Quiet sources at time zero
  initial
  begin
    serial_ev = '0;
    cc_one = '0;
    cc_two = '0;
    t2_tick = 1'b0;
    t2_count = 8'h00;
    t2_period = 8'h40;
    t1_ovf = 1'b0;
  end

  // Serial levels {master, multi, idle} and unit modes
  task automatic setlv(input logic [2:0] s, input capcomp_mode_e m);
  begin
    @(posedge sys_clk);
    {serial_ev.i2c_master, serial_ev.multi_master, serial_ev.module_idle} <= s;
    cc_one.mode <= m;
    cc_two.mode <= m;
  end
  endtask

  // One-cycle strobe; the closing edge keeps a gap before the next
  task automatic fire(input int k);
  begin
    @(posedge sys_clk);
    case (k)
      0: t1_ovf <= 1'b1;
      1: {t2_tick, t2_count} <= {1'b1, t2_period};
      2: cc_one.capture <= 1'b1;
      3: cc_one.match <= 1'b1;
      4: cc_two.capture <= 1'b1;
      5: cc_two.match <= 1'b1;
      6: serial_ev.xfer_done <= 1'b1;
      7: serial_ev.seq_done <= 1'b1;
      8: serial_ev.bus_start <= 1'b1;
      9: serial_ev.bus_stop <= 1'b1;
      // Tick with count off the period
      default: {t2_tick, t2_count} <= {1'b1, t2_period ^ 8'h01};
    endcase
    @(posedge sys_clk);
    {t1_ovf, t2_tick, cc_one.capture, cc_one.match} <= 4'h0;
    {cc_two.capture, cc_two.match} <= 2'h0;
    {serial_ev.xfer_done, serial_ev.seq_done} <= 2'h0;
    {serial_ev.bus_start, serial_ev.bus_stop} <= 2'h0;
    t2_count <= t2_count + 8'h02;
  end
  endtask
endmodule // pif_src

/* File: tb/tb_peripheral_interrupt_flags.sv */
`timescale 1ns/100ps

module tb_peripheral_interrupt_flags
  import pif_pkg::*;
;
  logic sys_clk;
  logic rst_b;
  reg_req_s reg_req;
  logic [7:0] rd_data;
  logic glob_en;
  serial_ev_s sev;
  capcomp_ev_s c1;
  capcomp_ev_s c2;
  logic tick;
  logic ovf;
  logic irq;
  logic [7:0] cnt;
  logic [7:0] per;
  int n_mismatch = 0;
  int num_checks = 0;
  // Entry: event, serial levels, mode, address, expected read
  logic [27:0] tbl [17] = '{28'h0410c01, 28'h1410c02, 28'h2410c04, 28'h3420c04,
    28'h4410d01, 28'h5420d01, 28'h6400c08, 28'h7400c08, 28'h8300c08,
    28'h9300c08, 28'h3430c00, 28'h5430d00, 28'h6000c00, 28'h8200c00, 28'ha400c00,
    28'h2000c00, 28'h4420d00};

  peripheral_interrupt_flags peripheral_interrupt_flags_i (.sys_clk(sys_clk),
    .rst_b(rst_b), .reg_req(reg_req), .rd_data(rd_data),
    .global_interrupt_enable(glob_en), .serial_ev(sev), .capcomp_one(c1),
    .capcomp_two(c2), .timer_two_tick(tick), .timer_two_count(cnt),
    .timer_two_period(per), .timer_one_overflow(ovf), .periph_irq(irq));

  pif_src pif_src_i (.sys_clk(sys_clk), .serial_ev(sev), .cc_one(c1), .cc_two(c2),
    .t2_tick(tick), .t2_count(cnt), .t2_period(per), .t1_ovf(ovf));

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
  begin
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  end
  endtask

  // Read data are looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
  begin
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 chk("rd_data", rd_data, exp);
  end
  endtask

  task automatic summarize();
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask

  // Clock, 50 ns period
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Watchdog, far beyond the few hundred cycles of the tests
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_b = 1'b0;
    reg_req = '0;
    glob_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (tbl[i])
    begin
      pif_src_i.setlv(tbl[i][22:20], capcomp_mode_e'(tbl[i][17:16]));
      pif_src_i.fire(int'(tbl[i][27:24]));
      rd(tbl[i][15:8], tbl[i][7:0]);
      rd(tbl[i][15:8], tbl[i][7:0]);
      chk("irq", {7'h00, irq}, 8'h00);
      wr(tbl[i][15:8], 8'h00);
      rd(tbl[i][15:8], 8'h00);
    end
    // Flags already clear when the enable goes up
    wr(8'h8c, 8'h01);
    pif_src_i.fire(0);
    #1 chk("irq", {7'h00, irq}, 8'h01);
    @(posedge sys_clk) glob_en <= 1'b0;
    @(posedge sys_clk) #1 chk("irq", {7'h00, irq}, 8'h00);
    @(posedge sys_clk) glob_en <= 1'b1;
    wr(8'h8c, 8'h00);
    #1 chk("irq", {7'h00, irq}, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h8d, 8'hff);
    rd(8'h8d, 8'h01);
    pif_src_i.setlv(3'h0, CC_CAPTURE);
    pif_src_i.fire(4);
    #1 chk("irq", {7'h00, irq}, 8'h01);
    wr(8'h0d, 8'hfe);
    #1 chk("irq", {7'h00, irq}, 8'h00);
    rd(8'h0d, 8'h00);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    // Event and software clear land on the same edge
    fork
      pif_src_i.fire(0);
      wr(8'h0c, 8'h00);
    join
    rd(8'h0c, 8'h01);
    @(posedge sys_clk) rst_b <= 1'b0;
    @(posedge sys_clk) rst_b <= 1'b1;
    rd(8'h0c, 8'h00);
    rd(8'h8d, 8'h00);
    summarize();
  end
endmodule // tb_peripheral_interrupt_flags
